// *** verilog/swl_pkg.sv ***
/*
  Shared constants and types for the single-wire triplet and block receive sequencer.
  Assumes a 40 MHz clock and an Avalon-MM register bus with byte addresses.
*/
`default_nettype none
package swl_pkg;
  // Clock and start latency
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int START_LAT_NS   = 1090;
  localparam int START_LAT_CYC  = (START_LAT_NS * 1000) / CLK_PERIOD_PS;

  // Register byte offsets
  localparam logic [8:0] OFS_CMD       = 9'h000;
  localparam logic [8:0] OFS_STATUS    = 9'h004;
  localparam logic [8:0] OFS_CFG       = 9'h008;
  localparam logic [8:0] OFS_TIME_LOW  = 9'h00C;
  localparam logic [8:0] OFS_TIME_AUX  = 9'h010;
  localparam logic [8:0] OFS_IRQ_STAT  = 9'h014;
  localparam logic [8:0] OFS_IRQ_MASK  = 9'h018;
  localparam logic [8:0] OFS_PTR       = 9'h01C;
  localparam logic [8:0] OFS_PTR_DATA  = 9'h020;
  localparam logic [8:0] OFS_SCRATCH   = 9'h100;

  // Command codes and field positions
  localparam logic [7:0] CMD_TRIPLET   = 8'h78;
  localparam logic [7:0] CMD_RECV      = 8'hE1;
  localparam int CMD_CODE_LSB          = 0;
  localparam int CMD_PARAM_LSB         = 8;
  localparam int BRANCH_BIT            = 7;
  localparam int BS_WIDTH              = 6;
  localparam int SCRATCH_DEPTH         = 64;
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam logic [2:0] TRIP_SLOT1    = 3'h1;
  localparam logic [2:0] TRIP_SLOT2    = 3'h2;

  // Slot lengths and timing reset values, in clock cycles
  localparam logic [15:0] SLOT_STD_CYC  = 16'h0AF0;
  localparam logic [15:0] SLOT_OD_CYC   = 16'h0190;
  localparam logic [31:0] TIME_LOW_RST  = 32'h00F0_0960;
  localparam logic [31:0] TIME_AUX_RST  = 32'h0190_00C8;
  localparam logic [3:0]  CFG_RST       = 4'h0;
  localparam logic [2:0]  IRQ_RST       = 3'h0;

  typedef struct packed {
    logic weak_pullup_resistor;
    logic strong_pullup_select;
    logic active_pullup_select;
    logic overdrive_speed_select;
  } cfg_type;

  typedef struct packed {
    logic [15:0] write_one_low_time;
    logic [15:0] write_zero_low_time;
  } time_low_type;

  typedef struct packed {
    logic [15:0] read_sample_time;
    logic [15:0] recovery_time;
  } time_aux_type;

  typedef struct packed {
    logic refused;
    logic recv_done;
    logic trip_done;
  } events_type;

  typedef enum logic [1:0] {
    OP_NONE    = 2'b00,
    OP_TRIPLET = 2'b01,
    OP_RECV    = 2'b10
  } op_type;
endpackage
`default_nettype wire

// *** verilog/swl_sequencer.sv ***
/*
  Single-wire bus sequencer: search triplet and block receive, Avalon-MM slave.
  Assumes ow_in comes from the open-drain line pin; output enable drives it low.
*/
// Local design decisions: register access over Avalon-MM and the placing of the registers.
// Functional notes
// (RULE1) Busy at command arrival: command ignored
// (RULE2) Triplet done within three slots plus 1.09us
// (RULE3) Line activity starts within 1.09us
// (RULE4) Triplet accept points reader at status
// (RULE5) Busy three slots; result flags at samples
// (RULE6) Triplet uses present speed, pullup, timings
// (RULE7) Parameter bit 7 is branch value
// (RULE8) Code E1h reads 1 to 63 bytes
// (RULE9) Receive only after earlier activity ends
// (RULE10) Receive done within count times 8 slots
// (RULE11) Busy for 8 slots times block size
// (RULE12) Bytes stored in order from 00h
// (RULE13) Block size zero reads one byte
// (RULE14) Receive uses present speed, pullup, timings
// (RULE15) Code 78h starts the search triplet
// (RULE16) Write slot chosen from two reads
// (RULE17) Host polls busy before using results
`timescale 1ns/1ps
`default_nettype none
module swl_sequencer (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [8:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ow_in,
  output logic             ow_out,
  output logic             ow_oe,
  output logic             active_pullup_en,
  output logic             strong_pullup_en,
  output logic             weak_pullup_sel,
  output logic             irq
);
  import swl_pkg::*;
  localparam int LAT_LIM = START_LAT_CYC;
  cfg_type          cfg_r;
  time_low_type     tlow_r;
  time_aux_type     taux_r;
  events_type       irq_stat_r, irq_mask_r, ev;
  op_type           op_r;
  logic [31:0]      rdata_r;
  logic [16:0]      slot_end_cyc;
  logic [15:0]      slot_cnt_r, low_cyc;
  logic [8:0]       rd_ptr_r;
  logic [7:0]       shift_r, cmd_code, cmd_param;
  logic [7:0]       scratch_r [SCRATCH_DEPTH];
  logic [5:0]       byte_idx_r, byte_last_r;
  logic [2:0]       bit_idx_r;
  logic             ack_r, ow_meta_r, ow_sync_r, slot_run_r, slot_w0_r, branch_r, spu_hold_r;
  logic             sbr_r, tsb_r, dir_r, line_busy, wr_acc, rd_acc, rd_cap, cmd_wr, cmd_known;
  logic             start_trip, start_recv, slot_end, sample_hit, dir_calc, op_done;
  // (RULE11) Busy spans every slot
  assign line_busy  = (op_r != OP_NONE);
  assign wr_acc     = ce && avs_write && ack_r;
  assign rd_acc     = ce && avs_read && ack_r;
  assign rd_cap     = ce && avs_read && !ack_r;
  assign cmd_code   = avs_writedata[CMD_CODE_LSB +: 8];
  assign cmd_param  = avs_writedata[CMD_PARAM_LSB +: 8];
  assign cmd_wr     = wr_acc && (avs_address == OFS_CMD);
  assign cmd_known  = (cmd_code == CMD_TRIPLET) || (cmd_code == CMD_RECV);
  // (RULE1) Refuse while busy
  assign start_trip = cmd_wr && !line_busy && (cmd_code == CMD_TRIPLET);
  // (RULE9) No overlap with running op
  assign start_recv = cmd_wr && !line_busy && (cmd_code == CMD_RECV);
  // Avalon handshake: one wait cycle; ce low keeps the wait
  assign avs_waitrequest = (avs_read || avs_write) && !(ack_r && ce);
  assign avs_readdata    = rdata_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  function automatic logic [31:0] reg_value(input logic [8:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a >= OFS_SCRATCH) begin
      v[7:0] = scratch_r[a[7:2]];
    end else begin
      case (a)
        OFS_STATUS:   v[3:0] = {dir_r, tsb_r, sbr_r, line_busy};
        OFS_CFG:      v[3:0] = cfg_r;
        OFS_TIME_LOW: v = tlow_r;
        OFS_TIME_AUX: v = taux_r;
        OFS_IRQ_STAT: v[2:0] = irq_stat_r;
        OFS_IRQ_MASK: v[2:0] = irq_mask_r;
        OFS_PTR:      v[8:0] = rd_ptr_r;
        default:      v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_cap) begin
      rdata_r <= (avs_address == OFS_PTR_DATA) ? reg_value(rd_ptr_r) : reg_value(avs_address);
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r      <= CFG_RST;
      tlow_r     <= TIME_LOW_RST;
      taux_r     <= TIME_AUX_RST;
      irq_mask_r <= IRQ_RST;
    end else if (wr_acc) begin
      case (avs_address)
        OFS_CFG:      cfg_r      <= avs_writedata[3:0];
        OFS_TIME_LOW: tlow_r     <= avs_writedata;
        OFS_TIME_AUX: taux_r     <= avs_writedata;
        OFS_IRQ_MASK: irq_mask_r <= avs_writedata[2:0];
        default:      cfg_r      <= cfg_r;
      endcase
    end
  end

  // (RULE4) Read pointer moves to status
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr_r <= OFS_STATUS;
    end else if (start_trip || start_recv) begin
      rd_ptr_r <= OFS_STATUS;
    end else if (wr_acc && avs_address == OFS_PTR) begin
      rd_ptr_r <= avs_writedata[8:0];
    end
  end

  // Events; set wins over read-clear
  assign ev.refused   = cmd_wr && (line_busy || !cmd_known);
  assign ev.trip_done = op_done && (op_r == OP_TRIPLET);
  assign ev.recv_done = op_done && (op_r == OP_RECV);
  // Clear at the capture edge, so no event slips between
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_r <= IRQ_RST;
    end else if (ce) begin
      irq_stat_r <= (rd_cap && avs_address == OFS_IRQ_STAT) ? ev : events_type'(irq_stat_r | ev);
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);
  // Line input synchroniser
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ow_meta_r <= 1'b1;
      ow_sync_r <= 1'b1;
    end else if (ce) begin
      ow_meta_r <= ow_in;
      ow_sync_r <= ow_meta_r;
    end
  end

  // (RULE6) Live speed and timing values
  // (RULE14) Same settings for receive slots
  assign slot_end_cyc = {1'b0, cfg_r.overdrive_speed_select ? SLOT_OD_CYC : SLOT_STD_CYC}
                      + {1'b0, taux_r.recovery_time};
  assign low_cyc    = slot_w0_r ? tlow_r.write_zero_low_time : tlow_r.write_one_low_time;
  assign slot_end   = slot_run_r && ({1'b0, slot_cnt_r} == slot_end_cyc - 17'h00001);
  assign sample_hit = slot_run_r && !slot_w0_r && (slot_cnt_r == taux_r.read_sample_time)
                    && !(op_r == OP_TRIPLET && bit_idx_r == TRIP_SLOT2);
  assign op_done    = slot_end && (((op_r == OP_TRIPLET) && (bit_idx_r == TRIP_SLOT2))
                    || ((op_r == OP_RECV) && (bit_idx_r == LAST_BIT)
                    && (byte_idx_r == byte_last_r)));

  // (RULE16) Branch choice from two reads
  // (RULE7) Both zero takes parameter bit
  assign dir_calc = sbr_r ? 1'b1 : (ow_sync_r ? 1'b0 : branch_r);

  assign ow_out           = 1'b0;
  assign ow_oe            = slot_run_r && (slot_cnt_r < low_cyc);
  assign active_pullup_en = cfg_r.active_pullup_select && slot_run_r && !ow_oe;
  assign strong_pullup_en = spu_hold_r;
  assign weak_pullup_sel  = cfg_r.weak_pullup_resistor;

  // Slot timer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_run_r <= 1'b0;
      slot_cnt_r <= 16'h0000;
    end else if (ce) begin
      if (start_trip || start_recv) begin
        // (RULE3) Line driven the next cycle
        slot_run_r <= 1'b1;
        slot_cnt_r <= 16'h0000;
      end else if (slot_end) begin
        slot_run_r <= !op_done;
        slot_cnt_r <= 16'h0000;
      end else if (slot_run_r) begin
        slot_cnt_r <= slot_cnt_r + 16'h0001;
      end
    end
  end

  // Operation sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_r        <= OP_NONE;
      bit_idx_r   <= 3'h0;
      byte_idx_r  <= 6'h00;
      byte_last_r <= 6'h00;
      branch_r    <= 1'b0;
      slot_w0_r   <= 1'b0;
    end else if (ce) begin
      if (start_trip) begin
        // (RULE15) Triplet start
        op_r      <= OP_TRIPLET;
        branch_r  <= cmd_param[BRANCH_BIT];
        bit_idx_r <= 3'h0;
        slot_w0_r <= 1'b0;
      end else if (start_recv) begin
        // (RULE8) Block receive start
        // (RULE13) Zero size gives one byte
        op_r        <= OP_RECV;
        bit_idx_r   <= 3'h0;
        byte_idx_r  <= 6'h00;
        byte_last_r <= (cmd_param[BS_WIDTH-1:0] == 6'h00) ? 6'h00
                     : cmd_param[BS_WIDTH-1:0] - 6'h01;
        slot_w0_r   <= 1'b0;
      end else if (op_done) begin
        // (RULE2) Ends after last slot
        // (RULE10) Ends after last byte
        op_r      <= OP_NONE;
        slot_w0_r <= 1'b0;
      end else if (slot_end) begin
        bit_idx_r <= bit_idx_r + 3'h1;
        if (op_r == OP_TRIPLET && bit_idx_r == TRIP_SLOT1) begin
          slot_w0_r <= !dir_r;
        end
        if (op_r == OP_RECV && bit_idx_r == LAST_BIT) begin
          byte_idx_r <= byte_idx_r + 6'h01;
        end
      end
    end
  end

  // (RULE5) Result flags at sample points
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sbr_r   <= 1'b0;
      tsb_r   <= 1'b0;
      dir_r   <= 1'b0;
      shift_r <= 8'h00;
    end else if (ce && sample_hit) begin
      if (op_r == OP_TRIPLET && bit_idx_r == 3'h0) begin
        sbr_r <= ow_sync_r;
      end else if (op_r == OP_TRIPLET) begin
        tsb_r <= ow_sync_r;
        dir_r <= dir_calc;
      end else begin
        shift_r <= {ow_sync_r, shift_r[7:1]};
      end
    end
  end

  // (RULE12) Bytes stored from location 00h
  always_ff @(posedge clk) begin
    if (ce && sample_hit && op_r == OP_RECV && bit_idx_r == LAST_BIT) begin
      scratch_r[byte_idx_r] <= {ow_sync_r, shift_r[7:1]};
    end
  end

  // Strong pullup after a receive
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      spu_hold_r <= 1'b0;
    end else if (ce) begin
      if (start_trip || start_recv || !cfg_r.strong_pullup_select) begin
        spu_hold_r <= 1'b0;
      end else if (ev.recv_done) begin
        spu_hold_r <= 1'b1;
      end
    end
  end

  // Assertion helpers
  logic [21:0] busy_cnt_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_r <= 22'h000000;
    end else if (ce) begin
      busy_cnt_r <= line_busy ? busy_cnt_r + 22'h000001 : 22'h000000;
    end
  end

  sequence s_trip_cmd;
    start_trip;
  endsequence
  sequence s_line_low;
    ow_oe;
  endsequence

  // (RULE1)
  a_busy_refuse: assert property (@(posedge clk) disable iff (sys_rst) // (RULE1)
    (cmd_wr && line_busy) |=> (op_r == $past(op_r)) && !$rose(slot_run_r))
    else $error("command accepted while busy");
  a_start_latency: assert property (@(posedge clk) disable iff (sys_rst) // (RULE3)
    (ce && (start_trip || start_recv)) |-> ##[1:LAT_LIM] s_line_low)
    else $error("line activity started late");
  a_ptr_status: assert property (@(posedge clk) disable iff (sys_rst) // (RULE4)
    (s_trip_cmd and ce) |=> (rd_ptr_r == OFS_STATUS) && (op_r == OP_TRIPLET))
    else $error("read pointer not at status");
  a_busy_hold: assert property (@(posedge clk) disable iff (sys_rst) // (RULE5)
    (line_busy && !op_done) |=> line_busy)
    else $error("busy dropped before op end");
  a_branch_both0: assert property (@(posedge clk) disable iff (sys_rst) // (RULE7)
    (ce && sample_hit && op_r == OP_TRIPLET && bit_idx_r == TRIP_SLOT1 && !sbr_r && !ow_sync_r)
    |=> dir_r == branch_r)
    else $error("branch value not used");
  a_write_kind: assert property (@(posedge clk) disable iff (sys_rst) // (RULE16)
    (op_r == OP_TRIPLET && bit_idx_r == TRIP_SLOT2 && slot_run_r) |-> slot_w0_r == !dir_r)
    else $error("triplet write slot wrong");
  a_bs_zero: assert property (@(posedge clk) disable iff (sys_rst) // (RULE13)
    (ce && start_recv && cmd_param[BS_WIDTH-1:0] == 6'h00) |=> byte_last_r == 6'h00)
    else $error("zero block size not one byte");
  a_trip_bound: assert property (@(posedge clk) disable iff (sys_rst) // (RULE2)
    (op_r == OP_TRIPLET) |-> busy_cnt_r <= 22'(3 * slot_end_cyc) + 22'(LAT_LIM))
    else $error("triplet too long");
  a_recv_bound: assert property (@(posedge clk) disable iff (sys_rst) // (RULE10)
    (op_r == OP_RECV) |-> busy_cnt_r <= 22'({byte_last_r, 3'h0} + 9'h008) * 22'(slot_end_cyc)
      + 22'(LAT_LIM))
    else $error("block receive too long");
  a_no_overlap: assert property (@(posedge clk) disable iff (sys_rst) // (RULE9)
    (ce && start_recv) |-> !slot_run_r && (op_r == OP_NONE))
    else $error("receive overlapped running op");
endmodule
`default_nettype wire

// *** dv/swl_slave_model.sv ***
/*
  Behavioural single-wire slave: answers each slot from a bit queue, records line levels.
  Assumes the line has a pull-up and the master pulls it low through ow_oe.
*/
`timescale 1ns/1ps
`default_nettype none
module swl_slave_model (
  input  wire logic clk,
  input  wire logic ow_oe,
  output logic      ow_in
);
  localparam int HOLD = 25;
  bit   tx_q[$];
  bit   rx_q[$];
  logic pull_r = 1'b0;
  logic line_d = 1'b1;
  int   cnt    = 0;
  // Wired-AND line with pull-up
  assign ow_in = !(ow_oe || pull_r);
  // Negedge keeps clear of the master's launch edge
  always @(negedge clk) begin
    line_d <= ow_in;
    if (line_d && !ow_in && cnt == 0) begin
      cnt <= 1;
      pull_r <= (tx_q.size() > 0) ? !tx_q.pop_front() : 1'b0;
    end else if (cnt > 0) begin
      cnt <= (cnt == HOLD) ? 0 : cnt + 1;
      if (cnt == HOLD) begin
        rx_q.push_back(ow_in);
        pull_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/swl_sequencer_test.sv ***
/*
  Self-checking bench for swl_sequencer: triplets and block receives against a model.
  Assumes swl_pkg and the slave model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module swl_sequencer_test;
  import swl_pkg::*;
  localparam int REC  = 10;
  localparam int SLOT = 400 + REC;
  logic        clk;
  logic        sys_rst;
  logic        ce;
  logic [8:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic        avs_waitrequest;
  logic        ow_in;
  logic        ow_oe;
  logic        ow_out;
  logic        apu_en;
  logic        spu_en;
  logic        wpu_sel;
  logic        irq;
  logic        r1;
  logic        r2;
  logic        v;
  logic        dir;
  logic [7:0]  exp_b[4];
  logic [8:0]  ra[6] = '{OFS_STATUS, OFS_CFG, OFS_TIME_LOW, OFS_TIME_AUX, OFS_IRQ_STAT, 9'h024};
  logic [31:0] rv[6] = '{32'h0, 32'h0, TIME_LOW_RST, TIME_AUX_RST, 32'h0, 32'h0};
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          t0;
  int          nb;
  int          apu_cnt = 0;
  int          slot_len = SLOT;

  swl_sequencer i_swl_sequencer (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ow_in(ow_in),
    .ow_out(ow_out), .ow_oe(ow_oe), .active_pullup_en(apu_en), .strong_pullup_en(spu_en),
    .weak_pullup_sel(wpu_sel), .irq(irq)
  );
  swl_slave_model i_swl_slave_model (.clk(clk), .ow_oe(ow_oe), .ow_in(ow_in));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (apu_en === 1'b1) apu_cnt <= apu_cnt + 1;
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One Avalon access, held until a rising edge samples waitrequest low
  task automatic bus(logic w, logic [8:0] a, logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Issue a command, then poll busy and bound its span
  task automatic run(logic [15:0] cmd, int slots, logic probe);
    int n;
    i_swl_slave_model.rx_q.delete();
    bus(1'b1, OFS_PTR, 32'h0000_0024);
    bus(1'b1, OFS_CMD, {16'h0, cmd});
    t0 = cyc;
    n = 0;
    @(negedge clk);
    while (ow_oe !== 1'b1 && n <= START_LAT_CYC) begin
      @(negedge clk);
      n++;
    end
    chk("start", n <= START_LAT_CYC, 1);
    bus(1'b0, OFS_PTR_DATA, 0);
    chk("ptr", rd[0], 1);
    if (probe) bus(1'b1, OFS_CMD, {16'h0, 8'h3F, CMD_RECV});
    do bus(1'b0, OFS_STATUS, 0);
    while (rd[0] === 1'b1 && cyc - t0 < slots * slot_len + 200);
    chk("busy_min", cyc - t0 >= slots * slot_len, 1);
    chk("busy_max", cyc - t0 <= slots * slot_len + START_LAT_CYC + 4, 1);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    test_done();
  end

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    void'($urandom(32'h589026E3));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ra[i], 0);
      chk("reset_val", rd, rv[i]);
    end
    chk("ow_out", ow_out, 0);
    bus(1'b1, OFS_CFG, 32'h3);
    bus(1'b1, OFS_TIME_LOW, {16'd6, 16'd60});
    bus(1'b1, OFS_TIME_AUX, {16'd15, 16'(REC)});
    bus(1'b1, OFS_IRQ_MASK, 32'h7);
    for (int i = 0; i < 8; i++) begin
      r1 = i[0];
      r2 = i[1];
      v = i[2];
      i_swl_slave_model.tx_q = {r1, r2, 1'b1};
      run({v, 7'($urandom), CMD_TRIPLET}, 3, i == 0);
      dir = (r1 & r2) | ((r1 ^ r2) ? r1 : v);
      chk("status", rd[3:0], {dir, r2, r1, 1'b0});
      chk("written", i_swl_slave_model.rx_q[2], dir);
      chk("irq_on", irq, 1);
      bus(1'b0, OFS_IRQ_STAT, 0);
      chk("irq_stat", rd[2:0], (i == 0) ? 3'h5 : 3'h1);
      @(negedge clk);
      chk("irq_off", irq, 0);
    end
    chk("apu", apu_cnt > 0, 1);
    bus(1'b1, OFS_CFG, 32'h2);
    slot_len = int'(SLOT_STD_CYC) + REC;
    i_swl_slave_model.tx_q = {1'b0, 1'b0, 1'b1};
    run({1'b1, 7'($urandom), CMD_TRIPLET}, 3, 1'b0);
    slot_len = SLOT;
    chk("status_std", rd[3:0], 4'h8);
    chk("written_std", i_swl_slave_model.rx_q[2], 1);
    bus(1'b0, OFS_IRQ_STAT, 0);
    chk("irq_stat_std", rd[2:0], 3'h1);
    bus(1'b1, OFS_CMD, 32'h0000_00A5);
    bus(1'b0, OFS_IRQ_STAT, 0);
    chk("unknown_code", rd[2:0], 3'h4);
    bus(1'b1, OFS_CFG, 32'hF);
    @(negedge clk);
    chk("weak", wpu_sel, 1);
    for (int k = 0; k < 2; k++) begin
      nb = k ? 3 : 1;
      bus(1'b1, OFS_IRQ_MASK, k ? 32'h7 : 32'h0);
      for (int b = 0; b < nb; b++) begin
        exp_b[b] = 8'($urandom);
        for (int j = 0; j < 8; j++) i_swl_slave_model.tx_q.push_back(exp_b[b][j]);
      end
      run({2'($urandom), 6'(k ? 3 : 0), CMD_RECV}, 8 * nb, 1'b0);
      chk("strong", spu_en, 1);
      chk("irq_mask", irq, k ? 1 : 0);
      bus(1'b1, OFS_IRQ_MASK, 32'h7);
      @(negedge clk);
      chk("irq_unmask", irq, 1);
      bus(1'b0, OFS_IRQ_STAT, 0);
      chk("irq_stat_rx", rd[2:0], 3'h2);
      for (int b = 0; b < nb; b++) begin
        bus(1'b0, OFS_SCRATCH + 9'(4 * b), 0);
        chk("scratch", rd[7:0], exp_b[b]);
      end
    end
    test_done();
  end
endmodule
`default_nettype wire
